// File: fle_pkg.sv
package fle_pkg;

    typedef logic [7:0] fle_byte_t;

    // Register offsets on the management register port
    localparam fle_byte_t FLE_THR_OFFSET = 8'h62;
    localparam fle_byte_t FLE_DUTY_OFFSET = 8'h63;

    // Power-on values
    localparam fle_byte_t FLE_THR_RESET = 8'h7F;
    localparam fle_byte_t FLE_DUTY_RESET = 8'h3F;
    localparam fle_byte_t FLE_RD_UNMAPPED = 8'h00;

    // Field layout
    localparam int FLE_THR_HALF_BIT = 7;
    localparam int FLE_THR_WHOLE_W = 7;
    localparam int FLE_DUTY_EXT_LSB = 6;
    localparam int FLE_DUTY_BASE_W = 6;

    // Temperature reading: eight whole-degree bits above the fraction
    localparam int FLE_TEMP_INT_W = 8;
    localparam int FLE_TEMP_FRAC_W = 3;
    localparam int FLE_HIRES_W = 9;
    localparam int FLE_LORES_W = 8;

    // Effective threshold width: entry plus offset, in half degrees at high resolution, whole degrees at low
    localparam int FLE_EFF_W = 10;
    localparam logic [9:0] FLE_LORES_SPAN = 10'h07F;

endpackage

// File: fle_cmp_if.sv
`timescale 1ns/100ps
interface fle_cmp_if
#(
    parameter int TEMP_W = 11
);
    logic [TEMP_W-1:0] temp;
    logic [7:0] thr;
    logic [7:0] offset;
    logic hires;
    logic exceeds;
    logic [9:0] eff_thr;

    modport ctl
    (
        output temp,
        output thr,
        output offset,
        output hires,
        input exceeds,
        input eff_thr
    );

    modport cmp
    (
        input temp,
        input thr,
        input offset,
        input hires,
        output exceeds,
        output eff_thr
    );
endinterface

// File: fle_cmp.sv
`timescale 1ns/100ps
module fle_cmp
#(
    parameter int TEMP_W = 11
)
(
    fle_cmp_if.cmp cif
);
    import fle_pkg::*;

    logic [FLE_EFF_W-1:0] temp_cut;
    logic [FLE_EFF_W-1:0] thr_sum;

    if (TEMP_W < FLE_HIRES_W)
    begin : g_width_chk
        $error("fle_cmp: temperature reading narrower than nine bits");
    end

    // Fraction below the used resolution is dropped, not rounded
    always_comb
    begin
        if (cif.hires)
        begin
            temp_cut = {1'b0, cif.temp[TEMP_W-1 -: FLE_HIRES_W]};
            // Offset counts whole degrees, so it moves up one bit
            thr_sum = {2'b00, cif.thr} + {1'b0, cif.offset, 1'b0};
        end
        else
        begin
            temp_cut = {2'b00, cif.temp[TEMP_W-1 -: FLE_LORES_W]};
            thr_sum = {3'b000, cif.thr[FLE_THR_WHOLE_W-1:0]}
                + {2'b00, cif.offset};
        end
    end

    // Both sides zero-extended: no negative threshold exists
    assign cif.eff_thr = thr_sum;
    assign cif.exceeds = temp_cut > thr_sum;
endmodule

// File: fle_entry_ten.sv
// Contract
// - Entry writes land only while unlock set
// - Threshold top bit zero in low resolution
// - Threshold range half or whole degree steps
// - Above threshold selects the paired duty
// - Compare nine or eight reading bits only
// - Threshold always non-negative, sign bit zero
// - Shared offset added to entry threshold
// - Duty top bits zero in low resolution
// - Extended duty only at 22.5 kHz
// - Low six duty bits form base duty
// - Reset threshold 0x7F, duty 0x3F
`timescale 1ns/100ps
module fle_entry_ten
#(
    parameter int TEMP_FRAC_W = 3
)
(
    input wire logic clk_sys,
    input wire logic reset,
    input wire fle_pkg::fle_byte_t reg_addr,
    input wire logic reg_wr_en,
    input wire fle_pkg::fle_byte_t reg_wdata,
    input wire logic reg_rd_en,
    output fle_pkg::fle_byte_t reg_rdata,
    input wire logic table_write_unlock,
    input wire logic temp_hires_mode,
    input wire logic duty_hires_mode,
    input wire logic pwm_22k5_sel,
    input wire fle_pkg::fle_byte_t table_temp_offset,
    input wire logic [fle_pkg::FLE_TEMP_INT_W+TEMP_FRAC_W-1:0] remote_temp,
    output logic entry_exceeded,
    output fle_pkg::fle_byte_t entry_duty,
    output logic write_blocked
);
    import fle_pkg::*;

    localparam int TEMP_W = FLE_TEMP_INT_W + TEMP_FRAC_W;

    if (TEMP_FRAC_W < 1)
    begin : g_frac_chk
        $error("fle_entry_ten: reading needs at least a half-degree bit");
    end

    fle_byte_t thr_r;
    fle_byte_t thr_nxt;
    fle_byte_t duty_r;
    fle_byte_t duty_nxt;
    fle_byte_t rdata_r;
    fle_byte_t rdata_nxt;
    logic exceeded_r;
    logic exceeded_nxt;
    fle_byte_t duty_out_r;
    fle_byte_t duty_out_nxt;
    logic blocked_r;
    logic blocked_nxt;
    logic boot_r;

    fle_byte_t thr_view;
    fle_byte_t duty_view;
    fle_byte_t duty_eff;
    logic ext_duty_en;
    logic hit_thr;
    logic hit_duty;

    fle_cmp_if #(.TEMP_W(TEMP_W)) cif ();

    fle_cmp #(.TEMP_W(TEMP_W)) u_cmp
    (
        .cif(cif)
    );

    assign cif.temp = remote_temp;
    assign cif.thr = thr_r;
    assign cif.offset = table_temp_offset;
    assign cif.hires = temp_hires_mode;

    assign hit_thr = reg_addr == FLE_THR_OFFSET;
    assign hit_duty = reg_addr == FLE_DUTY_OFFSET;

    // Stored bits survive a mode change; only the view is masked
    always_comb
    begin
        if (temp_hires_mode)
        begin
            thr_view = thr_r;
        end
        else
        begin
            thr_view = {1'b0, thr_r[FLE_THR_WHOLE_W-1:0]};
        end
        if (duty_hires_mode)
        begin
            duty_view = duty_r;
        end
        else
        begin
            duty_view = {2'b00, duty_r[FLE_DUTY_BASE_W-1:0]};
        end
    end

    // Extended duty needs both the mode and the fast PWM rate
    assign ext_duty_en = duty_hires_mode && pwm_22k5_sel;
    always_comb
    begin
        if (ext_duty_en)
        begin
            duty_eff = duty_r;
        end
        else
        begin
            duty_eff = {2'b00, duty_r[FLE_DUTY_BASE_W-1:0]};
        end
    end

    always_comb
    begin
        thr_nxt = thr_r;
        duty_nxt = duty_r;
        blocked_nxt = 1'b0;
        if (reg_wr_en && (hit_thr || hit_duty))
        begin
            if (table_write_unlock)
            begin
                if (hit_thr)
                begin
                    thr_nxt = reg_wdata;
                end
                else
                begin
                    duty_nxt = reg_wdata;
                end
            end
            else
            begin
                // Locked table: write dropped, flagged for one cycle
                blocked_nxt = 1'b1;
            end
        end
    end

    always_comb
    begin
        rdata_nxt = rdata_r;
        if (reg_rd_en)
        begin
            if (hit_thr)
            begin
                rdata_nxt = thr_view;
            end
            else if (hit_duty)
            begin
                rdata_nxt = duty_view;
            end
            else
            begin
                rdata_nxt = FLE_RD_UNMAPPED;
            end
        end
    end

    // Registered compare: one cycle of latency keeps outputs glitch free
    always_comb
    begin
        exceeded_nxt = cif.exceeds;
        duty_out_nxt = duty_eff;
    end

    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            thr_r <= FLE_THR_RESET;
            duty_r <= FLE_DUTY_RESET;
            rdata_r <= FLE_RD_UNMAPPED;
            exceeded_r <= 1'b0;
            duty_out_r <= FLE_DUTY_RESET;
            blocked_r <= 1'b0;
            boot_r <= 1'b0;
        end
        else
        begin
            thr_r <= thr_nxt;
            duty_r <= duty_nxt;
            rdata_r <= rdata_nxt;
            exceeded_r <= exceeded_nxt;
            duty_out_r <= duty_out_nxt;
            blocked_r <= blocked_nxt;
            boot_r <= 1'b1;
        end
    end

    assign reg_rdata = rdata_r;
    assign entry_exceeded = exceeded_r;
    assign entry_duty = duty_out_r;
    assign write_blocked = blocked_r;

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (reset);

    sequence s_wr_locked;
        reg_wr_en && !table_write_unlock;
    endsequence

    sequence s_wr_thr_open;
        reg_wr_en && table_write_unlock && hit_thr;
    endsequence

    sequence s_rd_thr;
        reg_rd_en && hit_thr;
    endsequence

    sequence s_rd_duty;
        reg_rd_en && hit_duty;
    endsequence

    property p_wr_locked;
        s_wr_locked |=> $stable(thr_r) && $stable(duty_r);
    endproperty
    a_wr_locked: assert property (p_wr_locked)
        else $error("entry changed while table locked");

    property p_wr_thr_open;
        s_wr_thr_open ##1 s_rd_thr |=> reg_rdata == ($past(reg_wdata, 2)
            & ($past(temp_hires_mode) ? 8'hFF : 8'h7F));
    endproperty
    a_wr_thr_open: assert property (p_wr_thr_open)
        else $error("unlocked threshold write not read back");

    property p_thr_lo_read;
        s_rd_thr and !temp_hires_mode |=> reg_rdata[FLE_THR_HALF_BIT] == 1'b0;
    endproperty
    a_thr_lo_read: assert property (p_thr_lo_read)
        else $error("threshold top bit visible in low resolution");

    property p_lo_range;
        !temp_hires_mode
            |-> cif.eff_thr <= {2'b00, table_temp_offset} + FLE_LORES_SPAN;
    endproperty
    a_lo_range: assert property (p_lo_range)
        else $error("low resolution threshold beyond range");

    property p_exceed;
        cif.exceeds |=> entry_exceeded && entry_duty == ($past(duty_r)
            & ($past(duty_hires_mode) && $past(pwm_22k5_sel) ? 8'hFF : 8'h3F));
    endproperty
    a_exceed: assert property (p_exceed)
        else $error("exceeded entry not driving paired duty");

    property p_frac_ignored;
        temp_hires_mode && $stable(remote_temp[TEMP_W-1 -: FLE_HIRES_W])
            && $stable(thr_r) && $stable(table_temp_offset)
            && $stable(temp_hires_mode) |-> $stable(cif.exceeds);
    endproperty
    a_frac_ignored: assert property (p_frac_ignored)
        else $error("fine fraction bits changed the compare");

    property p_nonneg;
        table_temp_offset == 8'h00 |-> cif.eff_thr[9:8] == 2'b00;
    endproperty
    a_nonneg: assert property (p_nonneg)
        else $error("threshold sign extended");

    property p_offset;
        temp_hires_mode
            |-> cif.eff_thr == {2'b00, thr_r} + {1'b0, table_temp_offset, 1'b0};
    endproperty
    a_offset: assert property (p_offset)
        else $error("offset not added to threshold");

    property p_duty_lo_read;
        s_rd_duty and !duty_hires_mode |=> reg_rdata[7:6] == 2'b00;
    endproperty
    a_duty_lo_read: assert property (p_duty_lo_read)
        else $error("duty extended bits visible in low resolution");

    property p_ext_rate;
        !pwm_22k5_sel |=> entry_duty[7:6] == 2'b00;
    endproperty
    a_ext_rate: assert property (p_ext_rate)
        else $error("extended duty used away from 22.5 kHz");

    property p_base_duty;
        1'b1 |=> entry_duty[5:0] == $past(duty_r[5:0]);
    endproperty
    a_base_duty: assert property (p_base_duty)
        else $error("base duty bits not passed through");

    property p_reset_vals;
        !boot_r |-> thr_r == FLE_THR_RESET && duty_r == FLE_DUTY_RESET;
    endproperty
    a_reset_vals: assert property (p_reset_vals)
        else $error("wrong power-on entry values");

endmodule

// File: fle_entry_ten_tb.sv
`timescale 1ns/100ps
module fle_entry_ten_tb;
    import fle_pkg::*;
    logic clk_sys = 1'b0;
    logic reset = 1'b1;
    fle_byte_t reg_addr = 8'h00;
    logic reg_wr_en = 1'b0;
    fle_byte_t reg_wdata = 8'h00;
    logic reg_rd_en = 1'b0;
    fle_byte_t reg_rdata;
    logic table_write_unlock = 1'b0;
    logic temp_hires_mode = 1'b1;
    logic duty_hires_mode = 1'b1;
    logic pwm_22k5_sel = 1'b1;
    fle_byte_t table_temp_offset = 8'h00;
    logic [10:0] remote_temp = 11'h000;
    logic entry_exceeded;
    fle_byte_t entry_duty;
    logic write_blocked;
    int n_errors = 0;
    int check_count = 0;
    // Behavioural copy of the two entry registers
    int thr_m = 'h7F;
    int duty_m = 'h3F;
    int off_i;
    // Read data stands until the next read, so it is checked every cycle
    int rd_last = 0;
    logic [1:0] md;

    always #20 clk_sys = ~clk_sys;

    fle_entry_ten #(.TEMP_FRAC_W(3)) dut_u
    (
        .clk_sys(clk_sys),
        .reset(reset),
        .reg_addr(reg_addr),
        .reg_wr_en(reg_wr_en),
        .reg_wdata(reg_wdata),
        .reg_rd_en(reg_rd_en),
        .reg_rdata(reg_rdata),
        .table_write_unlock(table_write_unlock),
        .temp_hires_mode(temp_hires_mode),
        .duty_hires_mode(duty_hires_mode),
        .pwm_22k5_sel(pwm_22k5_sel),
        .table_temp_offset(table_temp_offset),
        .remote_temp(remote_temp),
        .entry_exceeded(entry_exceeded),
        .entry_duty(entry_duty),
        .write_blocked(write_blocked)
    );

    task automatic check(string name, logic [7:0] exp, logic [7:0] seen);
        check_count++;
        if (seen !== exp)
        begin
            $display("Error %s expected %0h seen %0h", name, exp, seen);
            n_errors++;
        end
    endtask

    task automatic complete_run();
        $display("errors %0d checks %0d", n_errors, check_count);
        if (n_errors == 0 && check_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    function automatic logic [7:0] rd_m(logic [7:0] a);
        if (a == 8'h62)
            return temp_hires_mode ? 8'(thr_m) : 8'(thr_m & 'h7F);
        if (a == 8'h63)
            return duty_hires_mode ? 8'(duty_m) : 8'(duty_m & 'h3F);
        return 8'h00;
    endfunction

    // One register-port cycle; outputs checked just after the edge
    task automatic cyc(logic we, logic re, logic [7:0] a, logic [7:0] d);
        logic [7:0] exp_rd;
        logic exp_exc;
        logic [7:0] exp_duty;
        logic exp_blk;
        reg_wr_en = we;
        reg_rd_en = re;
        reg_addr = a;
        reg_wdata = d;
        off_i = table_temp_offset;
        exp_rd = rd_m(a);
        if (temp_hires_mode)
            exp_exc = int'(remote_temp[10:2]) > thr_m + 2 * off_i;
        else
            exp_exc = int'(remote_temp[10:3]) > (thr_m & 'h7F) + off_i;
        exp_duty = (duty_hires_mode && pwm_22k5_sel) ? 8'(duty_m)
                                                     : 8'(duty_m & 'h3F);
        exp_blk = we && !table_write_unlock && (a == 8'h62 || a == 8'h63);
        @(posedge clk_sys);
        if (we && table_write_unlock && a == 8'h62)
            thr_m = d;
        if (we && table_write_unlock && a == 8'h63)
            duty_m = d;
        #1;
        if (re)
            rd_last = exp_rd;
        check("reg_rdata", 8'(rd_last), reg_rdata);
        check("entry_exceeded", {7'h00, exp_exc}, {7'h00, entry_exceeded});
        check("entry_duty", exp_duty, entry_duty);
        check("write_blocked", {7'h00, exp_blk}, {7'h00, write_blocked});
    endtask

    initial
    begin
        void'($urandom(28870));
        repeat (2) @(posedge clk_sys);
        #1;
        reset = 1'b0;
        cyc(1'b0, 1'b1, 8'h62, 8'h00);
        cyc(1'b0, 1'b1, 8'h63, 8'h00);
        // Locked writes must be refused, then unmapped address
        cyc(1'b1, 1'b0, 8'h62, 8'hA5);
        cyc(1'b1, 1'b0, 8'h63, 8'hC1);
        cyc(1'b0, 1'b1, 8'h62, 8'h00);
        cyc(1'b0, 1'b1, 8'h63, 8'h00);
        cyc(1'b0, 1'b1, 8'h64, 8'h00);
        table_write_unlock = 1'b1;
        cyc(1'b1, 1'b0, 8'h64, 8'h11);
        // Threshold edge: equal reading is not above, fraction dropped
        cyc(1'b1, 1'b0, 8'h62, 8'h80);
        remote_temp = 11'h203;
        cyc(1'b0, 1'b1, 8'h62, 8'h00);
        remote_temp = 11'h204;
        cyc(1'b0, 1'b0, 8'h62, 8'h00);
        table_temp_offset = 8'h01;
        cyc(1'b0, 1'b0, 8'h62, 8'h00);
        temp_hires_mode = 1'b0;
        cyc(1'b0, 1'b1, 8'h62, 8'h00);
        // Extended duty bits under every mode and rate pairing
        cyc(1'b1, 1'b0, 8'h63, 8'hC5);
        for (int i = 0; i < 4; i++)
        begin
            {duty_hires_mode, pwm_22k5_sel} = 2'(i);
            cyc(1'b0, 1'b1, 8'h63, 8'h00);
        end
        for (int i = 0; i < 400; i++)
        begin
            md = 2'($urandom);
            table_write_unlock = ($urandom % 4) != 0;
            temp_hires_mode = md[0];
            duty_hires_mode = md[1];
            pwm_22k5_sel = 1'($urandom);
            table_temp_offset = 8'($urandom % 80);
            remote_temp = 11'($urandom);
            md = 2'($urandom);
            cyc(md[0], !md[0] && md[1], 8'h61 + 8'($urandom % 4),
                8'($urandom));
        end
        reset = 1'b1;
        #40;
        reset = 1'b0;
        thr_m = 'h7F;
        duty_m = 'h3F;
        rd_last = 0;
        temp_hires_mode = 1'b1;
        duty_hires_mode = 1'b1;
        cyc(1'b0, 1'b1, 8'h62, 8'h00);
        cyc(1'b0, 1'b1, 8'h63, 8'h00);
        complete_run();
    end
endmodule
